// ==== logic/dc_input_consts.svh ====
// Constants of the DC input enable policy: offsets, field positions, resets
// Assumes a 16-bit register port with a 4-bit word address
`ifndef DC_INPUT_CONSTS_SVH
`define DC_INPUT_CONSTS_SVH

// ****************************************
// Register offsets (word index)
// ****************************************
`define REG_CONFIG          4'h0
`define REG_CONTROL         4'h1
`define REG_STATUS          4'h2
`define REG_OV_LIMIT        4'h3
`define REG_OC_LIMIT        4'h4
`define REG_OP_LIMIT        4'h5
`define REG_R_SETPOINT      4'h6

// ****************************************
// Configuration fields
// ****************************************
`define CFG_ALLOW_REMOTE    0
`define CFG_POWERUP_RESTORE 1
`define CFG_LOSS_AUTO       2
`define CFG_EXIT_AUTO       3
`define CFG_FAST_REG        4
`define CFG_R_MODE          5
`define CFG_SB_BOTH_WAYS    6
`define CFG_SB_INVERT       7
`define CFG_RANGE_10V       8
`define CFG_USED_MASK       16'h01FF
`define CFG_ANALOG_MASK     16'h01C0
`define CFG_FACTORY         16'h0001
`define CFG_RESET           16'h0001

// ****************************************
// Control command fields
// ****************************************
`define CTL_SWITCH_ON       0
`define CTL_SWITCH_OFF      1
`define CTL_LEAVE_REMOTE    2
`define CTL_RESET_YES       3
`define CTL_RESET_ENTER     4

// ****************************************
// Status fields
// ****************************************
`define ST_ENABLE           0
`define ST_REMOTE           1
`define ST_LOCAL_ONLY       2
`define ST_SUPPLY_LOSS      3
`define ST_OV               4
`define ST_OC               5
`define ST_OP               6
`define ST_STANDBY          7
`define ST_R_MODE           8
`define ST_ANALOG_FITTED    9

// ****************************************
// Reset values
// ****************************************
`define LIMIT_FACTORY       16'hFFFF
`define SETPOINT_FACTORY    16'h0000
`define WORD_ZERO           16'h0000

`endif

// ==== logic/dc_input_pkg.sv ====
// Types shared by the DC input enable policy files
// Assumes nothing of its surroundings
package dc_input_pkg;

   typedef logic [15:0] word_t;
   typedef logic [3:0]  addr_t;
   typedef logic [31:0] wide_t;

   // Control location, one-hot
   typedef enum logic [1:0] {
      CTRL_LOCAL  = 2'b01,
      CTRL_REMOTE = 2'b10
   } ctrl_mode_e;

endpackage

// ==== logic/pin_sync.sv ====
// Two-stage synchroniser for one pin level
// Assumes the pin is asynchronous to clk_i
module pin_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic meta_reg;
   logic level_reg;

   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg  <= 1'b0;
         level_reg <= 1'b0;
      end else if (ce_i) begin
         meta_reg  <= pin_i;
         level_reg <= meta_reg;
      end
   end

   assign level_o = level_reg;

endmodule

// ==== logic/over_limit.sv ====
// Limit comparator with a sticky alarm flag
// Assumes value and limit come from logic on clk_i
module over_limit (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire dc_input_pkg::wide_t  value_i,
   input  wire dc_input_pkg::wide_t  limit_i,
   input  wire logic                 clear_i,
   output logic                      exceed_o,
   output logic                      alarm_o
);
   import dc_input_pkg::*;

   logic exceed_reg;
   logic alarm_reg;
   wire  exceed_next = value_i > limit_i;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         exceed_reg <= 1'b0;
         alarm_reg  <= 1'b0;
      end else if (ce_i) begin
         exceed_reg <= exceed_next;
         alarm_reg  <= exceed_reg | (alarm_reg & ~clear_i);
      end
   end

   assign exceed_o = exceed_reg;
   assign alarm_o  = alarm_reg;

endmodule

// ==== logic/dc_input_enable_policy.sv ====
// DC input enable policy of an electronic load: settings, alarms and on/off control
// Assumes a register port on clk_i, pins asynchronous, stored settings on clk_i
//
// How it works
// R01: Remote not allowed rejects digital and analog control
// R02: Remote not allowed shows local-only status
// R03: Power-up policy Off keeps input off
// R04: Power-up policy Restore reloads saved enable state
// R05: Supply loss Off: stays off until switch-on
// R06: Supply loss Auto: back on if was on
// R07: Exit policy Off: leaving remote disables input
// R08: Exit policy Auto: leaving remote keeps state
// R09: Selector for slow or fast voltage regulation
// R10: Resistance mode and setpoint only when enabled
// R11: Off-only pin action never enables input
// R12: Both-ways pin re-enables only if enabled elsewhere
// R13: Inverted polarity flips the standby pin level
// R14: Analog range selects 5 V or 10 V
// R15: Analog settings exist only with option fitted
// R16: Confirmed factory reset restores all defaults
// R17: Over-voltage raises alarm and disables input
// R18: Over-current raises alarm and disables input
// R19: Over-power raises alarm and disables input
// R20: Settings writable only while input is off; the R setpoint is written while on too
// R21: Standby pin synchronised, acted on next cycle
// R22: Reset loads power-up Off, other policies stored
`include "dc_input_consts.svh"

module dc_input_enable_policy (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   input  wire dc_input_pkg::addr_t addr_i,
   input  wire dc_input_pkg::word_t wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output dc_input_pkg::word_t      rdata_o,
   input  wire dc_input_pkg::word_t stored_cfg_i,
   input  wire logic                restore_i,
   input  wire logic                saved_enable_i,
   input  wire logic                dig_enter_remote_i,
   input  wire logic                dig_exit_remote_i,
   input  wire logic                dig_on_i,
   input  wire logic                dig_off_i,
   input  wire logic                remote_standby_pin_i,
   input  wire logic                analog_fitted_i,
   input  wire logic                supply_loss_alarm_i,
   input  wire dc_input_pkg::word_t volt_i,
   input  wire dc_input_pkg::word_t curr_i,
   output logic                     dc_enable_o,
   output logic                     remote_active_o,
   output logic                     local_only_o,
   output logic                     fast_reg_o,
   output logic                     r_mode_o,
   output dc_input_pkg::word_t      r_setpoint_o,
   output logic                     range_10v_o,
   output logic                     over_voltage_alarm_o,
   output logic                     over_current_alarm_o,
   output logic                     over_power_alarm_o,
   output logic                     factory_reset_o
);
   import dc_input_pkg::*;

   // ****************************************
   // State
   // ****************************************
   word_t      cfg_reg;
   word_t      ov_limit_reg;
   word_t      oc_limit_reg;
   word_t      op_limit_reg;
   word_t      r_set_reg;
   word_t      rdata_reg;
   ctrl_mode_e mode_reg;
   ctrl_mode_e mode_next;
   logic       enable_reg;
   logic       enable_next;
   logic       loaded_reg;
   logic       sb_prev_reg;
   logic       sb_armed_reg;
   logic       sb_armed_next;
   logic       loss_prev_reg;
   logic       loss_was_on_reg;
   logic       factory_reg;
   word_t      cfg_next;

   // ****************************************
   // Synchronised pins
   // ****************************************
   logic sb_level;
   logic loss_level;
   logic fitted;

   pin_sync u_sync_standby (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_i   (remote_standby_pin_i),
      .level_o (sb_level)
   ); // R21
   pin_sync u_sync_loss (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_i   (supply_loss_alarm_i),
      .level_o (loss_level)
   );
   pin_sync u_sync_fitted (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pin_i   (analog_fitted_i),
      .level_o (fitted)
   );

   // ****************************************
   // Register decode
   // ****************************************
   wire sel_cfg    = addr_i == `REG_CONFIG;
   wire sel_ctl    = addr_i == `REG_CONTROL;
   wire sel_status = addr_i == `REG_STATUS;
   wire sel_ov     = addr_i == `REG_OV_LIMIT;
   wire sel_oc     = addr_i == `REG_OC_LIMIT;
   wire sel_op     = addr_i == `REG_OP_LIMIT;
   wire sel_rset   = addr_i == `REG_R_SETPOINT;
   wire ctl_wr     = wr_i & sel_ctl;
   wire cfg_unlock = ~enable_reg; // R20

   wire allow      = cfg_reg[`CFG_ALLOW_REMOTE];
   wire is_remote  = mode_reg == CTRL_REMOTE;
   wire is_local   = mode_reg == CTRL_LOCAL;

   wire factory_cmd = ctl_wr & wdata_i[`CTL_RESET_YES] & wdata_i[`CTL_RESET_ENTER]
                      & cfg_unlock; // R16
   wire alarm_clear = wr_i & sel_status;

   // Analog settings hold their value while the option is absent
   wire [15:0] analog_keep = fitted ? `WORD_ZERO : `CFG_ANALOG_MASK; // R15
   wire [15:0] cfg_wmask   = `CFG_USED_MASK & ~analog_keep;

   // ****************************************
   // Limit alarms
   // ****************************************
   wide_t power;
   logic  ov_exceed;
   logic  oc_exceed;
   logic  op_exceed;

   // Power limit compares against the upper half of the product
   assign power = volt_i * curr_i;

   over_limit u_ov (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .value_i  ({`WORD_ZERO, volt_i}),
      .limit_i  ({`WORD_ZERO, ov_limit_reg}),
      .clear_i  (alarm_clear & wdata_i[`ST_OV]),
      .exceed_o (ov_exceed),
      .alarm_o  (over_voltage_alarm_o)
   ); // R17
   over_limit u_oc (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .value_i  ({`WORD_ZERO, curr_i}),
      .limit_i  ({`WORD_ZERO, oc_limit_reg}),
      .clear_i  (alarm_clear & wdata_i[`ST_OC]),
      .exceed_o (oc_exceed),
      .alarm_o  (over_current_alarm_o)
   ); // R18
   over_limit u_op (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .value_i  (power),
      .limit_i  ({op_limit_reg, 16'hFFFF}),
      .clear_i  (alarm_clear & wdata_i[`ST_OP]),
      .exceed_o (op_exceed),
      .alarm_o  (over_power_alarm_o)
   ); // R19

   wire any_trip  = ov_exceed | oc_exceed | op_exceed;
   wire any_alarm = over_voltage_alarm_o | over_current_alarm_o | over_power_alarm_o;
   // No switch-on while an alarm stands, so an alarm cannot be overridden
   wire on_block  = any_alarm | any_trip | loss_level;

   // ****************************************
   // Switch requests
   // ****************************************
   wire panel_on  = ctl_wr & wdata_i[`CTL_SWITCH_ON] & is_local;
   wire panel_off = ctl_wr & wdata_i[`CTL_SWITCH_OFF];
   wire dig_on    = dig_on_i & allow & is_remote; // R01
   wire dig_off   = dig_off_i & allow & is_remote; // R01

   // Standby level, 1 means standby asked for
   wire sb_active = sb_level ^ cfg_reg[`CFG_SB_INVERT]; // R13
   wire sb_usable = allow & fitted; // R01
   wire sb_rise   = sb_usable & sb_active & ~sb_prev_reg; // R21
   wire sb_fall   = sb_usable & ~sb_active & sb_prev_reg;
   wire sb_on     = sb_fall & cfg_reg[`CFG_SB_BOTH_WAYS] & sb_armed_reg; // R11 R12

   wire loss_fall = ~loss_level & loss_prev_reg;
   wire loss_on   = loss_fall & cfg_reg[`CFG_LOSS_AUTO] & loss_was_on_reg; // R05 R06

   // Leaving remote, by panel, command or withdrawn permission
   wire exit_evt  = is_remote & ((ctl_wr & wdata_i[`CTL_LEAVE_REMOTE])
                    | dig_exit_remote_i | ~allow);
   wire exit_off  = exit_evt & ~cfg_reg[`CFG_EXIT_AUTO]; // R07 R08
   wire boot_on   = stored_cfg_i[`CFG_POWERUP_RESTORE] & saved_enable_i; // R03 R04
   wire user_on   = panel_on | dig_on;

   always_comb begin
      enable_next = enable_reg;
      if ((user_on | sb_on | loss_on) & ~on_block) begin
         enable_next = 1'b1;
      end
      if (panel_off | dig_off | sb_rise | exit_off) begin
         enable_next = 1'b0;
      end
      if (restore_i) begin
         enable_next = boot_on & ~on_block;
      end
      if (any_trip | loss_level | factory_cmd) begin
         enable_next = 1'b0;
      end
   end

   // Pin may switch on only after another location switched on
   always_comb begin
      sb_armed_next = sb_armed_reg;
      if (enable_next & ~enable_reg & ~sb_on) begin
         sb_armed_next = 1'b1;
      end
      if (factory_cmd) begin
         sb_armed_next = 1'b0;
      end
   end // R12

   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         CTRL_LOCAL: begin
            if (dig_enter_remote_i & allow) begin
               mode_next = CTRL_REMOTE;
            end
         end
         CTRL_REMOTE: begin
            if (exit_evt) begin
               mode_next = CTRL_LOCAL;
            end
         end
         default: mode_next = CTRL_LOCAL;
      endcase
      if (factory_cmd) begin
         mode_next = CTRL_LOCAL;
      end
   end // R01

   // ****************************************
   // Configuration
   // ****************************************
   always_comb begin
      cfg_next = cfg_reg;
      if (~loaded_reg) begin
         cfg_next[`CFG_LOSS_AUTO] = stored_cfg_i[`CFG_LOSS_AUTO];
         cfg_next[`CFG_EXIT_AUTO] = stored_cfg_i[`CFG_EXIT_AUTO];
      end // R22
      if (restore_i) begin
         cfg_next = (stored_cfg_i & cfg_wmask) | (cfg_reg & analog_keep);
      end
      if (wr_i & sel_cfg & cfg_unlock) begin
         cfg_next = (wdata_i & cfg_wmask) | (cfg_reg & analog_keep); // R15 R20
      end
      if (factory_cmd) begin
         cfg_next = `CFG_FACTORY; // R16
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_reg    <= `CFG_RESET; // R22
         loaded_reg <= 1'b0;
      end else if (ce_i) begin
         cfg_reg    <= cfg_next;
         loaded_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ov_limit_reg <= `LIMIT_FACTORY;
         oc_limit_reg <= `LIMIT_FACTORY;
         op_limit_reg <= `LIMIT_FACTORY;
         r_set_reg    <= `SETPOINT_FACTORY;
      end else if (ce_i) begin
         if (factory_cmd) begin
            ov_limit_reg <= `LIMIT_FACTORY; // R16
            oc_limit_reg <= `LIMIT_FACTORY;
            op_limit_reg <= `LIMIT_FACTORY;
            r_set_reg    <= `SETPOINT_FACTORY;
         end else if (wr_i & cfg_unlock) begin
            if (sel_ov) ov_limit_reg <= wdata_i; // R20
            if (sel_oc) oc_limit_reg <= wdata_i;
            if (sel_op) op_limit_reg <= wdata_i;
         end
         if (wr_i & sel_rset & cfg_reg[`CFG_R_MODE] & ~factory_cmd) begin
            r_set_reg <= wdata_i; // R10
         end
      end
   end

   // ****************************************
   // Enable state
   // ****************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_reg      <= 1'b0; // R03
         mode_reg        <= CTRL_LOCAL;
         sb_prev_reg     <= 1'b0;
         sb_armed_reg    <= 1'b0;
         loss_prev_reg   <= 1'b0;
         loss_was_on_reg <= 1'b0;
         factory_reg     <= 1'b0;
      end else if (ce_i) begin
         enable_reg    <= enable_next;
         mode_reg      <= mode_next;
         sb_prev_reg   <= sb_active;
         sb_armed_reg  <= sb_armed_next;
         loss_prev_reg <= loss_level;
         factory_reg   <= factory_cmd;
         if (loss_level & ~loss_prev_reg) begin
            loss_was_on_reg <= enable_reg; // R06
         end else if (loss_fall | user_on) begin
            loss_was_on_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Read back
   // ****************************************
   word_t status;
   word_t rd_value;

   assign status = {6'h00, fitted, cfg_reg[`CFG_R_MODE], sb_active,
                    over_power_alarm_o, over_current_alarm_o, over_voltage_alarm_o,
                    loss_level, ~allow, is_remote, enable_reg};
   assign rd_value = sel_cfg    ? cfg_reg :
                     sel_status ? status :
                     sel_ov     ? ov_limit_reg :
                     sel_oc     ? oc_limit_reg :
                     sel_op     ? op_limit_reg :
                     sel_rset   ? r_set_reg : `WORD_ZERO;

   // Data stand in each cycle after rd_i is high, zero otherwise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= `WORD_ZERO;
      end else if (ce_i) begin
         rdata_reg <= rd_i ? rd_value : `WORD_ZERO;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o         = rdata_reg;
   assign dc_enable_o     = enable_reg;
   assign remote_active_o = is_remote;
   assign local_only_o    = ~allow; // R02
   assign fast_reg_o      = cfg_reg[`CFG_FAST_REG]; // R09
   assign r_mode_o        = cfg_reg[`CFG_R_MODE]; // R10
   assign r_setpoint_o    = r_set_reg;
   assign range_10v_o     = cfg_reg[`CFG_RANGE_10V]; // R14
   assign factory_reset_o = factory_reg; // R16

endmodule

// ==== tb/dc_input_enable_policy_chk.sv ====
// Checker of the DC input policy, bound to its top module
// Assumes one clock, clk_i, and the asynchronous reset rst_i
`include "dc_input_consts.svh"

module dc_input_enable_policy_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        restore_i,
   input wire logic        dig_enter_remote_i,
   input wire logic        dc_enable_o,
   input wire logic        remote_active_o,
   input wire logic        local_only_o,
   input wire logic        fast_reg_o,
   input wire logic        r_mode_o,
   input wire logic [15:0] r_setpoint_o,
   input wire logic        range_10v_o,
   input wire logic        over_voltage_alarm_o,
   input wire logic        over_current_alarm_o,
   input wire logic        over_power_alarm_o,
   input wire logic        factory_reset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ****
   // Assertions
   // ****
   chk_remote_entry: assert property ($rose(remote_active_o) |->
      $past(dig_enter_remote_i) && ($past(local_only_o) == 1'b0))
      else $error("bad remote entry");
   chk_local_idle: assert property (ce_i && local_only_o |=> !remote_active_o)
      else $error("remote while local only");
   chk_ov_off: assert property (over_voltage_alarm_o |-> !dc_enable_o)
      else $error("on during voltage alarm");
   chk_oc_off: assert property (over_current_alarm_o |-> !dc_enable_o)
      else $error("on during current alarm");
   chk_op_off: assert property (over_power_alarm_o |-> !dc_enable_o)
      else $error("on during power alarm");
   chk_setpoint_lock: assert property (ce_i && wr_i && !r_mode_o &&
      addr_i == `REG_R_SETPOINT |=> $stable(r_setpoint_o))
      else $error("setpoint taken");
   chk_cfg_lock: assert property (ce_i && wr_i && dc_enable_o && !restore_i &&
      addr_i == `REG_CONFIG |=> $stable({fast_reg_o, r_mode_o, local_only_o, range_10v_o}))
      else $error("locked config changed");
   chk_cfg_write: assert property (ce_i && wr_i && !dc_enable_o && !restore_i &&
      addr_i == `REG_CONFIG |=> fast_reg_o == $past(wdata_i[`CFG_FAST_REG]) &&
      r_mode_o == $past(wdata_i[`CFG_R_MODE]) &&
      local_only_o == !$past(wdata_i[`CFG_ALLOW_REMOTE]))
      else $error("config write lost");
   chk_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == `WORD_ZERO)
      else $error("stray read data");
   chk_factory_vals: assert property (factory_reset_o |-> !dc_enable_o &&
      !local_only_o && !fast_reg_o && !r_mode_o && !range_10v_o &&
      r_setpoint_o == `SETPOINT_FACTORY)
      else $error("factory value missed");

   cover property ($rose(remote_active_o));
   cover property ($rose(over_power_alarm_o));
   cover property (factory_reset_o);
endmodule

bind dc_input_enable_policy dc_input_enable_policy_chk dc_input_enable_policy_chk_i (.*);

// ==== tb/remote_side_model.sv ====
// Remote side: digital pulses, standby pin, supply state
// Assumes the bench calls its tasks after a rising edge
module remote_side_model (
   input  wire logic clk_i,
   output logic      enter_o,
   output logic      exit_o,
   output logic      on_o,
   output logic      off_o,
   output logic      pin_o,
   output logic      loss_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {enter_o, exit_o, on_o, off_o, pin_o, loss_o} = 6'h00;
   end

   // One-cycle command: 0 enter, 1 exit, 2 on, 3 off
   task automatic send(input int k);
      @(posedge clk_i);
      {enter_o, exit_o, on_o, off_o} <= 4'(4'h8 >> k);
      @(posedge clk_i);
      {enter_o, exit_o, on_o, off_o} <= 4'h0;
      @(negedge clk_i);
   endtask

   // Levels held until the next call: 0 standby pin, 1 supply lost
   task automatic level(input int k, input logic v);
      @(posedge clk_i);
      if (k == 0)
         pin_o <= v;
      else
         loss_o <= v;
   endtask
endmodule

// ==== tb/dc_input_enable_policy_tb_top.sv ====
// Self-checking bench of the DC input policy
// Assumes design, checker and model compiled first
`include "dc_input_consts.svh"

module dc_input_enable_policy_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dc_input_pkg::*;

   logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic        restore_i = 1'b0, saved_enable_i = 1'b0, analog_fitted_i = 1'b1;
   addr_t       addr_i = 4'h0;
   word_t       wdata_i = 16'h0000, stored_cfg_i = 16'h000E;
   word_t       volt_i = 16'h0000, curr_i = 16'h0000, rdata_o, r_setpoint_o, x, y;
   logic        dig_enter_remote_i, dig_exit_remote_i, dig_on_i, dig_off_i;
   logic        remote_standby_pin_i, supply_loss_alarm_i, dc_enable_o, remote_active_o;
   logic        local_only_o, fast_reg_o, r_mode_o, range_10v_o, factory_reset_o;
   logic        over_voltage_alarm_o, over_current_alarm_o, over_power_alarm_o;
   logic [31:0] seed = 32'h0000002A;
   int          n_mismatch = 0, comparisons = 0;
   word_t       eqv [3] = '{16'h1000, 16'h0000, 16'h0400};
   word_t       eqc [3] = '{16'h0000, 16'h1000, 16'h0400};
   word_t       pcf [4] = '{16'h0001, 16'h0041, 16'h0001, 16'h0005};

   dc_input_enable_policy dc_input_enable_policy_i (.*);
   remote_side_model remote_side_model_i (.clk_i(clk_i), .enter_o(dig_enter_remote_i),
      .exit_o(dig_exit_remote_i), .on_o(dig_on_i), .off_o(dig_off_i),
      .pin_o(remote_standby_pin_i), .loss_o(supply_loss_alarm_i));

   always #25 clk_i = ~clk_i;

   // ****
   // Helpers
   // ****
   function automatic word_t xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic cmp(input word_t got, input word_t exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input addr_t a, input word_t d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rdc(input addr_t a, input word_t exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      cmp(rdata_o, exp);
   endtask
   // Bounded wait for enable e
   task automatic wen(input logic e, input int s);
      repeat (s) @(negedge clk_i);
      for (int k = 0; k < 8 && dc_enable_o !== e; k++) @(negedge clk_i);
      cmp(16'(dc_enable_o), 16'(e));
   endtask
   task automatic sw(input logic e);
      wr(`REG_CONTROL, e ? 16'h0001 : 16'h0002);
      wen(e, 1);
   endtask
   task automatic meas(input word_t v, input word_t c);
      @(posedge clk_i);
      volt_i <= v;
      curr_i <= c;
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end

   // ****
   // Scenarios
   // ****
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rdc(`REG_CONFIG, 16'h000D);
      note("reset");
      for (int k = 0; k < 6; k++) begin
         x = xs() & `CFG_USED_MASK;
         wr(`REG_CONFIG, x);
         rdc(`REG_CONFIG, x);
         cmp({12'h000, fast_reg_o, r_mode_o, range_10v_o, local_only_o},
             {12'h000, x[4], x[5], x[8], ~x[0]});
      end
      // Analog fields freeze while the option is absent
      analog_fitted_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      y = xs() & `CFG_USED_MASK;
      wr(`REG_CONFIG, y);
      rdc(`REG_CONFIG, (y & ~`CFG_ANALOG_MASK) | (x & `CFG_ANALOG_MASK));
      analog_fitted_i <= 1'b1;
      wr(4'hF, xs());
      rdc(4'hF, `WORD_ZERO);
      note("config");
      wr(`REG_CONFIG, 16'h0001);
      x = xs();
      wr(`REG_R_SETPOINT, x);
      cmp(r_setpoint_o, `SETPOINT_FACTORY);
      ce_i <= 1'b0;
      wr(`REG_CONFIG, 16'h0021);
      ce_i <= 1'b1;
      rdc(`REG_CONFIG, 16'h0001);
      wr(`REG_CONFIG, 16'h0021);
      wr(`REG_R_SETPOINT, x);
      cmp(r_setpoint_o, x);
      sw(1'b1);
      wr(`REG_CONFIG, 16'h0011);
      rdc(`REG_CONFIG, 16'h0021);
      sw(1'b0);
      note("lock");
      wr(`REG_OV_LIMIT, 16'h1000);
      wr(`REG_OC_LIMIT, 16'h1000);
      wr(`REG_OP_LIMIT, 16'h0010);
      for (int k = 0; k < 3; k++) begin
         sw(1'b1);
         meas(eqv[k], eqc[k]);
         wen(1'b1, 6);
         meas(eqv[k] << 1, eqc[k] << 1);
         wen(1'b0, 1);
         rdc(`REG_STATUS, 16'h0300 | (16'h0010 << k));
         cmp({13'h0000, over_power_alarm_o, over_current_alarm_o, over_voltage_alarm_o},
             16'h0001 << k);
         meas(16'h0000, 16'h0000);
         wr(`REG_STATUS, 16'h0010 << k);
         rdc(`REG_STATUS, 16'h0300);
      end
      note("alarms");
      wr(`REG_CONFIG, 16'h0000);
      rdc(`REG_STATUS, 16'h0204);
      remote_side_model_i.send(0);
      remote_side_model_i.send(2);
      wen(1'b0, 6);
      cmp({15'h0000, remote_active_o}, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         wr(`REG_CONFIG, k[0] ? 16'h0009 : 16'h0001);
         remote_side_model_i.send(0);
         remote_side_model_i.send(2);
         wen(1'b1, 1);
         if (k[1])
            wr(`REG_CONTROL, 16'h0004);
         else
            remote_side_model_i.send(1);
         wen(k[0], 6);
         cmp({15'h0000, remote_active_o}, 16'h0000);
         remote_side_model_i.send(3);
         sw(1'b0);
      end
      note("remote");
      for (int k = 0; k < 4; k++) begin
         wr(`REG_CONFIG, pcf[k]);
         sw(1'b1);
         remote_side_model_i.level(k[1], 1'b1);
         wen(1'b0, 1);
         remote_side_model_i.level(k[1], 1'b0);
         wen(k[0], 6);
         sw(1'b1);
         sw(1'b0);
      end
      wr(`REG_CONFIG, 16'h0081);
      remote_side_model_i.level(0, 1'b1);
      wr(`REG_CONTROL, 16'h0001);
      wen(1'b1, 6);
      remote_side_model_i.level(0, 1'b0);
      wen(1'b0, 1);
      wr(`REG_CONFIG, 16'h0001);
      remote_side_model_i.level(1, 1'b1);
      remote_side_model_i.level(1, 1'b0);
      wen(1'b0, 6);
      note("standby_supply");
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         stored_cfg_i <= k[0] ? 16'h0003 : 16'h0001;
         saved_enable_i <= k[1];
         restore_i <= 1'b1;
         @(posedge clk_i);
         restore_i <= 1'b0;
         wen(k[0] & k[1], 6);
         sw(1'b0);
      end
      note("power_up");
      wr(`REG_CONFIG, 16'h01F0);
      wr(`REG_R_SETPOINT, xs() | 16'h0001);
      wr(`REG_OV_LIMIT, 16'h0123);
      wr(`REG_CONTROL, 16'h0018);
      for (int k = 0; k < 4 && factory_reset_o !== 1'b1; k++) @(negedge clk_i);
      cmp({15'h0000, factory_reset_o}, 16'h0001);
      rdc(`REG_CONFIG, `CFG_FACTORY);
      rdc(`REG_OV_LIMIT, `LIMIT_FACTORY);
      cmp(r_setpoint_o, `SETPOINT_FACTORY);
      note("factory");
      give_verdict();
   end
endmodule
